// ==== hw/adc_sequencer.sv ====
// Purpose: powers the converter and walks through one conversion sequence
// Assumes: start is a one-cycle pulse, ignored while busy
// Notes: one step per measured input, step length a parameter
`timescale 1ns/1ns
`default_nettype none
`include "cell_adc_consts.svh"
module adc_sequencer
  import cell_adc_pkg::*;
#(
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES,
  parameter logic [15:0] STEP_CYCLES = `STEP_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to register side
  seq_link_if.seq link
);
  typedef struct packed {
    pwr_state_t state;
    logic [15:0] timer;
    logic [3:0] steps;
    logic done;
  } seq_regs_t;
  localparam logic [15:0] SETTLE_LOAD = 16'(SETTLE_CYCLES - 1);

  seq_regs_t r;
  seq_regs_t next_r;

  // number of inputs measured: cells, then sensors, then aux input
  function automatic logic [3:0] stepCount(input seq_plan_t p);
    logic [3:0] n;
    n = {1'b0, p.cellCount} + 4'h1;
    n = n + {3'h0, p.tempSel[0]} + {3'h0, p.tempSel[1]} + {3'h0, p.auxSel};
    return n;
  endfunction

  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    case (r.state)
      PWR_OFF:
      begin
        if (link.start)
        begin
          next_r.steps = stepCount(link.plan);
          // forced-on converter is already settled
          if (link.forceOn)
          begin
            next_r.state = PWR_CONVERT;
            next_r.timer = STEP_CYCLES - 16'h0001;
          end
          else
          begin
            next_r.state = PWR_SETTLE;
            next_r.timer = SETTLE_LOAD;
          end
        end
      end
      PWR_SETTLE:
      begin
        if (r.timer == 16'h0000)
        begin
          next_r.state = PWR_CONVERT;
          next_r.timer = STEP_CYCLES - 16'h0001;
        end
        else
          next_r.timer = r.timer - 16'h0001;
      end
      PWR_CONVERT:
      begin
        if (r.timer != 16'h0000)
          next_r.timer = r.timer - 16'h0001;
        else if (r.steps > 4'h1)
        begin
          next_r.steps = r.steps - 4'h1;
          next_r.timer = STEP_CYCLES - 16'h0001;
        end
        else
        begin
          next_r.state = PWR_OFF;
          next_r.done = 1'b1;
        end
      end
      default:
        next_r.state = PWR_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign link.busy = (r.state != PWR_OFF);
  assign link.powered = link.forceOn || (r.state != PWR_OFF);
  assign link.done = r.done;
endmodule
`default_nettype wire

// ==== hw/cell_adc_consts.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the converter control block
// Assumes: 8-bit registers at byte offsets, 20 MHz clock
// Notes: definitions only
`ifndef CELL_ADC_CONSTS_SVH
`define CELL_ADC_CONSTS_SVH
`define OFS_HIGH_CELL_FLAGS 8'h22
`define OFS_LOW_CELL_FLAGS 8'h23
`define OFS_PARITY_FIRST 8'h24
`define OFS_PARITY_SECOND 8'h25
`define OFS_CONVERSION_SETUP 8'h30
`define OFS_SAMPLE_TRIGGER 8'h34
`define OFS_FAULT_STATUS 8'h21
`define SETUP_RESET 8'h00
`define SETUP_WRITE_MASK 8'h7F
`define BIT_FORCE_ON 6
`define POS_TEMP_SEL 4
`define BIT_AUX_SEL 3
`define POS_CELL_SEL 0
`define BIT_HIGH_SUMMARY 0
`define BIT_LOW_SUMMARY 1
`define BIT_SAMPLE_TRIGGER 0
`define CELL_FLAG_MASK 8'h3F
`define PARITY_SECOND_MASK 8'h0F
`define CELL_SEL_MAX 3'h5
`define CLK_MHZ 20
`define SETTLE_US 10
`define SETTLE_CYCLES (`SETTLE_US * `CLK_MHZ)
`define STEP_CYCLES 16'h0078
`endif

// ==== hw/cell_adc_pkg.sv ====
// Purpose: types shared by the converter control block
// Assumes: nothing beyond the constants header
// Notes: types only
package cell_adc_pkg;
  typedef enum logic [1:0] {PWR_OFF, PWR_SETTLE, PWR_CONVERT} pwr_state_t;
  typedef struct packed {
    logic [1:0] tempSel;
    logic auxSel;
    logic [2:0] cellCount;
  } seq_plan_t;
endpackage

// ==== hw/cell_adc_select_and_fault_flags.sv ====
// Purpose: converter setup register, per-cell fault flags and configuration parity results
// Assumes: register port is a parallel byte port driven by the serial front end on clk
// Notes: fault and parity sources arrive from pins or other logic and are synchronised
// Function
// - overvoltage flags bits 5-0 show which cells hold an overvoltage fault
// - undervoltage flags bits 5-0 show which cells hold an undervoltage fault
// - per-cell flags show which cells hold a fault now, and clear while the summary fault flags stay set
// - parity register 0x24 reports eight protected register parity bits, 7 down to 0
// - parity register 0x25 reports four spare register parity bits in 3-0
// - setup bit 6 set keeps converter powered regardless of conversion state
// - bit 6 clear: power up on request, settle, convert, power down
// - bits 5-4 select temperature sensors: none, first, second, both
// - bit 3 includes the auxiliary analog input in next sequence
// - bits 2-0 set measured cell count, code 101 means cells 1-6
// - codes 110 and 111 measure cell 1 only
`timescale 1ns/1ns
`default_nettype none
`include "cell_adc_consts.svh"
module cell_adc_select_and_fault_flags
  import cell_adc_pkg::*;
#(
  parameter int CELLS = 6,
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES,
  parameter logic [15:0] STEP_CYCLES = `STEP_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // fault comparators and parity checker
  input wire logic [CELLS-1:0] cellHighIn,
  input wire logic [CELLS-1:0] cellLowIn,
  input wire logic [7:0] parityFirstIn,
  input wire logic [3:0] paritySecondIn,
  // converter side
  output logic converterPowered,
  output logic conversionBusy,
  output logic conversionDone,
  output logic [1:0] tempSensorSelect,
  output logic auxAnalogSelect,
  output logic [CELLS-1:0] cellMeasureMask,
  output logic highCellSummary,
  output logic lowCellSummary
);
  typedef struct packed {
    logic [CELLS-1:0] highMeta;
    logic [CELLS-1:0] highSync;
    logic [CELLS-1:0] lowMeta;
    logic [CELLS-1:0] lowSync;
    logic [7:0] parAMeta;
    logic [7:0] parASync;
    logic [3:0] parBMeta;
    logic [3:0] parBSync;
    logic [CELLS-1:0] highFlags;
    logic [CELLS-1:0] lowFlags;
    logic highSummary;
    logic lowSummary;
    logic [7:0] setup;
    logic startPulse;
    seq_plan_t plan;
    logic [7:0] rdata;
  } top_regs_t;

  top_regs_t r;
  top_regs_t next_r;
  seq_link_if link ();

  // map a cell-select code to a count code, unused codes fall back to cell 1
  function automatic logic [2:0] cellCode(input logic [2:0] code);
    return (code > `CELL_SEL_MAX) ? 3'h0 : code;
  endfunction

  // widen a flag vector to a byte, upper bits zero
  function automatic logic [7:0] toByte(input logic [CELLS-1:0] v);
    logic [7:0] b;
    b = '0;
    b[CELLS-1:0] = v;
    return b & `CELL_FLAG_MASK;
  endfunction

  always_comb
  begin
    next_r = r;
    next_r.startPulse = 1'b0;
    next_r.highMeta = cellHighIn;
    next_r.highSync = r.highMeta;
    next_r.lowMeta = cellLowIn;
    next_r.lowSync = r.lowMeta;
    next_r.parAMeta = parityFirstIn;
    next_r.parASync = r.parAMeta;
    next_r.parBMeta = paritySecondIn;
    next_r.parBSync = r.parBMeta;
    // flags follow the live comparator state
    next_r.highFlags = r.highSync;
    next_r.lowFlags = r.lowSync;
    if (regWrite && regAddr == `OFS_FAULT_STATUS)
    begin
      if (regWdata[`BIT_HIGH_SUMMARY])
        next_r.highSummary = 1'b0;
      if (regWdata[`BIT_LOW_SUMMARY])
        next_r.lowSummary = 1'b0;
    end
    // a new fault wins over a clear in the same cycle
    if (|r.highSync)
      next_r.highSummary = 1'b1;
    if (|r.lowSync)
      next_r.lowSummary = 1'b1;
    if (regWrite && regAddr == `OFS_CONVERSION_SETUP)
      next_r.setup = regWdata & `SETUP_WRITE_MASK;
    // selections are latched at start so a later write cannot alter a running sequence
    if (regWrite && regAddr == `OFS_SAMPLE_TRIGGER && regWdata[`BIT_SAMPLE_TRIGGER] && !link.busy)
    begin
      next_r.startPulse = 1'b1;
      next_r.plan.tempSel = r.setup[`POS_TEMP_SEL +: 2];
      next_r.plan.auxSel = r.setup[`BIT_AUX_SEL];
      next_r.plan.cellCount = cellCode(r.setup[`POS_CELL_SEL +: 3]);
    end
    next_r.rdata = 8'h00;
    if (regRead)
    begin
      case (regAddr)
        `OFS_HIGH_CELL_FLAGS: next_r.rdata = toByte(r.highFlags);
        `OFS_LOW_CELL_FLAGS: next_r.rdata = toByte(r.lowFlags);
        `OFS_PARITY_FIRST: next_r.rdata = r.parASync;
        `OFS_PARITY_SECOND: next_r.rdata = {4'h0, r.parBSync} & `PARITY_SECOND_MASK;
        `OFS_CONVERSION_SETUP: next_r.rdata = r.setup;
        `OFS_FAULT_STATUS: next_r.rdata = {6'h00, r.lowSummary, r.highSummary};
        default: next_r.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.setup <= `SETUP_RESET;
    end
    else
      r <= next_r;
  end

  assign link.plan = r.plan;
  assign link.forceOn = r.setup[`BIT_FORCE_ON];
  assign link.start = r.startPulse;

  adc_sequencer #(
    .SETTLE_CYCLES(SETTLE_CYCLES),
    .STEP_CYCLES(STEP_CYCLES)
  ) u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .link(link)
  );

  // selection outputs show the plan of the sequence in flight
  always_comb
  begin
    cellMeasureMask = '0;
    for (int i = 0; i < CELLS; i++)
      cellMeasureMask[i] = (3'(i) <= r.plan.cellCount);
  end

  assign regRdata = r.rdata;
  assign converterPowered = link.powered;
  assign conversionBusy = link.busy;
  assign conversionDone = link.done;
  assign tempSensorSelect = r.plan.tempSel;
  assign auxAnalogSelect = r.plan.auxSel;
  assign highCellSummary = r.highSummary;
  assign lowCellSummary = r.lowSummary;
endmodule
`default_nettype wire

// ==== hw/seq_link_if.sv ====
// Purpose: carries the sequence plan and handshake between top and sequencer
// Assumes: single clock
// Notes: top drives plan and start, sequencer answers
`timescale 1ns/1ns
`default_nettype none
interface seq_link_if;
  import cell_adc_pkg::*;
  seq_plan_t plan;
  logic forceOn;
  logic start;
  logic busy;
  logic powered;
  logic done;
  modport ctrl (output plan, output forceOn, output start, input busy, input powered, input done);
  modport seq (input plan, input forceOn, input start, output busy, output powered, output done);
endinterface
`default_nettype wire

// ==== test/cell_adc_checker.sv ====
// Purpose: port assertions for the converter control block
// Assumes: one clock, async active-low reset
// Notes: bound to the top module
`timescale 1ns/1ns
`default_nettype none
module cell_adc_checker #(parameter int CELLS = 6)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdata,
  // faults and converter
  input wire logic [CELLS-1:0] cellHighIn,
  input wire logic [CELLS-1:0] cellLowIn,
  input wire logic converterPowered,
  input wire logic conversionBusy,
  input wire logic conversionDone,
  input wire logic [CELLS-1:0] cellMeasureMask,
  input wire logic highCellSummary,
  input wire logic lowCellSummary
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // four samples cover the two sync flops plus the flag stage
  sequence high_held; (|cellHighIn) [*4]; endsequence
  sequence low_held; (|cellLowIn) [*4]; endsequence
  a_high_summary: assert property (high_held |=> highCellSummary)
    else $error("high summary missing");
  a_low_summary: assert property (low_held |=> lowCellSummary)
    else $error("low summary missing");
  a_busy_powered: assert property (conversionBusy |-> converterPowered)
    else $error("busy while unpowered");
  a_done_pulse: assert property (conversionDone |=> !conversionDone)
    else $error("done longer than one cycle");
  a_done_at_end: assert property ($fell(conversionBusy) |-> conversionDone)
    else $error("sequence ended without done");
  a_mask_shape: assert property ($onehot0(cellMeasureMask + 1'b1))
    else $error("mask not a run from cell one");
  a_plan_stable: assert property (conversionBusy && $past(conversionBusy) |->
    $stable({cellMeasureMask, converterPowered})) else $error("plan moved mid sequence");
  a_flag_reserved: assert property ($past(regRead) && $past(regAddr) inside {8'h22, 8'h23}
    |-> regRdata[7:6] == 2'h0) else $error("flag reserved bits set");
  a_parity_reserved: assert property ($past(regRead) && $past(regAddr) == 8'h25
    |-> regRdata[7:4] == 4'h0) else $error("parity reserved bits set");
endmodule
bind cell_adc_select_and_fault_flags cell_adc_checker #(.CELLS(CELLS)) u_chk (.clk(clk), .rst_n(rst_n),
  .regRead(regRead), .regAddr(regAddr), .regRdata(regRdata), .cellHighIn(cellHighIn), .cellLowIn(cellLowIn),
  .converterPowered(converterPowered), .conversionBusy(conversionBusy), .conversionDone(conversionDone),
  .cellMeasureMask(cellMeasureMask), .highCellSummary(highCellSummary), .lowCellSummary(lowCellSummary));
`default_nettype wire

// ==== test/reg_host_model.sv ====
// Purpose: host side of the register port
// Assumes: drives on the falling edge
// Notes: read data taken one cycle after the strobe
`timescale 1ns/1ns
`default_nettype none
module reg_host_model
(
  // clock
  input wire logic clk,
  // register port
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata
);
  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWdata = {1'b0, d[6:0]};
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    regWdata = ~regWdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    d = regRdata;
  endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Purpose: register-level tests of the converter control block
// Assumes: short settle and step counts
// Notes: inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int SETTLE = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic regWrite, regRead, converterPowered, conversionBusy, conversionDone, auxAnalogSelect;
  logic highCellSummary, lowCellSummary;
  logic [7:0] regAddr, regWdata, regRdata, parityFirstIn, rdv, v;
  logic [3:0] paritySecondIn;
  logic [5:0] cellHighIn, cellLowIn, cellMeasureMask;
  logic [1:0] tempSensorSelect;
  int errors = 0;
  int n_tests = 0;
  int busyAuto, busyOn;
  always #25 clk = ~clk;
  reg_host_model u_host (.clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata));
  cell_adc_select_and_fault_flags #(.SETTLE_CYCLES(SETTLE), .STEP_CYCLES(16'h0004)) u_dut (.clk(clk),
    .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .cellHighIn(cellHighIn), .cellLowIn(cellLowIn), .parityFirstIn(parityFirstIn),
    .paritySecondIn(paritySecondIn), .converterPowered(converterPowered), .conversionBusy(conversionBusy),
    .conversionDone(conversionDone), .tempSensorSelect(tempSensorSelect), .auxAnalogSelect(auxAnalogSelect),
    .cellMeasureMask(cellMeasureMask), .highCellSummary(highCellSummary), .lowCellSummary(lowCellSummary));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, rdv);
    chk(rdv, exp);
  endtask
  // trigger, then count busy cycles; bounded so a stuck sequencer cannot hang
  task automatic run(output int n);
    logic seen;
    seen = 1'b0;
    n = 0;
    u_host.wr(8'h34, 8'h01);
    // the start pulse is registered first, so busy rises one edge after the write lands
    @(negedge clk);
    while (conversionBusy === 1'b1 && n < 500)
    begin
      @(negedge clk);
      n++;
      seen |= conversionDone;
    end
    seen |= conversionDone;
    chk({7'h00, seen}, 8'h01);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #(50 * 20000);
    errors++;
    final_report();
  end
  initial
  begin
    cellHighIn = 6'h00;
    cellLowIn = 6'h00;
    parityFirstIn = 8'h00;
    paritySecondIn = 4'h0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rchk(8'h30, 8'h00);
    rchk(8'h22, 8'h00);
    cellHighIn = 6'h24;
    cellLowIn = 6'h09;
    repeat (5) @(negedge clk);
    rchk(8'h22, 8'h24);
    rchk(8'h23, 8'h09);
    chk({6'h00, lowCellSummary, highCellSummary}, 8'h03);
    cellHighIn = 6'h00;
    cellLowIn = 6'h00;
    repeat (5) @(negedge clk);
    u_host.wr(8'h21, 8'h03);
    @(negedge clk);
    chk({6'h00, lowCellSummary, highCellSummary}, 8'h00);
    cellHighIn = 6'h01;
    repeat (5) @(negedge clk);
    u_host.wr(8'h21, 8'h01);
    rchk(8'h21, 8'h01);
    cellHighIn = 6'h00;
    repeat (5) @(negedge clk);
    u_host.wr(8'h21, 8'h01);
    rchk(8'h21, 8'h00);
    u_host.wr(8'h22, 8'hFF);
    rchk(8'h22, 8'h00);
    $display("test flags done");
    parityFirstIn = 8'hA5;
    paritySecondIn = 4'hC;
    repeat (5) @(negedge clk);
    rchk(8'h24, 8'hA5);
    u_host.wr(8'h25, 8'hFF);
    rchk(8'h25, 8'h0C);
    $display("test parity done");
    for (int i = 0; i < 8; i++)
    begin
      v = {2'h0, 2'(i), i[0], 3'(i)};
      u_host.wr(8'h30, v);
      rchk(8'h30, v);
      run(busyAuto);
      chk({6'h00, tempSensorSelect}, {6'h00, 2'(i)});
      chk({7'h00, auxAnalogSelect}, {7'h00, i[0]});
      chk({2'h0, cellMeasureMask}, (i > 5) ? 8'h01 : 8'h3F >> (5 - i));
      chk({7'h00, converterPowered}, 8'h00);
    end
    $display("test setup done");
    u_host.wr(8'h30, 8'h00);
    run(busyAuto);
    u_host.wr(8'h30, 8'h40);
    chk({7'h00, converterPowered}, 8'h01);
    run(busyOn);
    chk(8'(busyAuto - busyOn), 8'(SETTLE));
    chk({7'h00, converterPowered}, 8'h01);
    $display("test power done");
    final_report();
  end
endmodule
`default_nettype wire
